// ---- core/home_pkg.sv ----
// package for the home-return sequencer: register map, fields, states, timing
// assumes a single pclk domain at 200 MHz and an APB master with 32-bit data
package home_pkg;
    localparam logic [7:0] reg_ctrl = 8'h00;
    localparam logic [7:0] reg_speed = 8'h04;
    localparam logic [7:0] reg_home_pos = 8'h08;
    localparam logic [7:0] reg_dwell = 8'h0c;
    localparam logic [7:0] reg_stop_tlim = 8'h10;
    localparam logic [7:0] reg_int_tlim = 8'h14;
    localparam logic [7:0] reg_fwd_tlim = 8'h18;
    localparam logic [7:0] reg_rev_tlim = 8'h1c;
    localparam logic [7:0] reg_accel = 8'h20;
    localparam logic [7:0] reg_status = 8'h24;
    localparam logic [7:0] reg_mask = 8'h28;
    localparam logic [7:0] reg_position = 8'h2c;
    // ctrl fields
    localparam int ctrl_dir_bit = 4;
    localparam int ctrl_two_station_bit = 5;
    localparam logic [3:0] method_data_set = 4'h2;
    localparam logic [3:0] method_stopper = 4'h3;
    localparam logic [3:0] method_ignore = 4'h4;
    // status event bits, live bits sit above them
    localparam int ev_done = 0;
    localparam int ev_contact = 1;
    localparam int ev_tlim = 2;
    localparam int ev_w = 3;
    localparam int live_done_bit = 8;
    localparam int live_busy_bit = 9;
    // reset values
    localparam logic [31:0] ctrl_rst = 32'h0000_0000;
    localparam logic [15:0] tlim_rst = 16'h7fff;
    localparam logic [15:0] accel_rst = 16'h0001;
    // timing: dwell counted in milliseconds
    localparam int clk_period_ns = 5;
    localparam int ms_in_ns = 1000000;
    localparam int cycles_per_ms = ms_in_ns / clk_period_ns;
    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_press = 2'b01,
        st_dwell = 2'b11,
        st_jog = 2'b10
    } home_state_e;
    // cyclic link bits from the host
    typedef struct packed {
        logic auto_manual_select;
        logic [4:0] point_table_select_low;
        logic [2:0] point_table_select_high;
        logic pos_speed_spec_select;
        logic internal_torque_limit_select;
        logic start;
        logic jog_fwd;
        logic jog_rev;
        logic servo_on;
    } host_cmd_s;
endpackage : home_pkg

// ---- core/speed_ramp.sv ----
// acceleration limiter for the speed command
// assumes the step is a per-cycle speed increment set by software
module speed_ramp
    import home_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] target,
    input wire logic [W-1:0] step,
    output logic [W-1:0] speed
);
    logic [W:0] sum;
    logic [W-1:0] next_speed;

    // ramps up by step, stops at once since only acceleration is shaped
    assign sum = {1'b0, speed} + {1'b0, step};
    assign next_speed = (speed >= target) ? target
                      : (sum[W-1:0] >= target || sum[W]) ? target : sum[W-1:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            speed <= '0;
        else
            speed <= next_speed;
    end
endmodule : speed_ramp

// ---- core/home_return.sv ----
// home-return sequencer: data setting, stopper and servo-on home methods
// assumes host link bits synchronous to pclk; motor torque fed back as signed value
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module home_return
    import home_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int CYC_PER_MS = cycles_per_ms
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire host_cmd_s host_cmd,
    input wire logic signed [15:0] motor_torque,
    output logic home_return_done,
    output logic torque_limit_reached,
    output logic [15:0] speed_cmd,
    output logic dir_cmd,
    output logic [15:0] torque_limit_cmd,
    output logic [POS_W-1:0] position,
    output logic irq
);
    generate
        if (POS_W < 16 || POS_W > 32)
            $error("POS_W must lie between 16 and 32");
        if (CYC_PER_MS < 1)
            $error("CYC_PER_MS must be at least one");
    endgenerate

    logic [31:0] ctrl;
    logic [15:0] home_speed, stop_tlim, int_tlim, fwd_tlim, rev_tlim, accel;
    logic [15:0] dwell_ms;
    logic [POS_W-1:0] home_pos;
    logic [ev_w-1:0] status, mask;
    home_state_e state;
    logic [31:0] ms_cnt;
    logic [15:0] dwell_cnt;
    logic servo_on_q;

    // bus decode
    wire setup = psel && !penable;
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    wire mapped = (paddr <= reg_position) && (paddr[1:0] == 2'b00);
    wire rd_status = rd_done && (paddr == reg_status);
    wire [POS_W-1:0] home_pos_w = pwdata[POS_W-1:0];

    // mode decode from the host bits
    wire [3:0] method = ctrl[3:0];
    wire no_point = (host_cmd.point_table_select_low == 5'h00)
                 && (host_cmd.point_table_select_high == 3'h0);
    wire home_mode = host_cmd.auto_manual_select && no_point
                  && (!ctrl[ctrl_two_station_bit] || host_cmd.pos_speed_spec_select);
    wire start_home = home_mode && host_cmd.start && (state == st_idle || state == st_jog);
    wire start_data = start_home && (method == method_data_set);
    wire start_stop = start_home && (method == method_stopper);
    wire servo_on_rise = host_cmd.servo_on && !servo_on_q;
    wire ignore_home = (method == method_ignore) && servo_on_rise;
    wire jog_req = home_mode && (method == method_data_set)
                && (host_cmd.jog_fwd ^ host_cmd.jog_rev);

    // torque limits in effect
    wire [15:0] stop_eff = (host_cmd.internal_torque_limit_select && int_tlim < stop_tlim)
                         ? int_tlim : stop_tlim;
    wire pressing = (state == st_press) || (state == st_dwell);
    wire [15:0] next_tlim = pressing ? stop_eff
                          : (host_cmd.internal_torque_limit_select ? int_tlim : tlim_rst);
    wire [15:0] torque_abs = motor_torque[15] ? 16'(-motor_torque) : 16'(motor_torque);
    wire next_reached = (!motor_torque[15] && torque_abs >= fwd_tlim)
                     || (motor_torque[15] && torque_abs >= rev_tlim)
                     || (torque_abs >= torque_limit_cmd);

    // dwell timing
    wire ms_tick = (ms_cnt == 32'(CYC_PER_MS - 1));
    wire dwell_end = (state == st_dwell) && (dwell_cnt >= dwell_ms);
    wire contact = (state == st_press) && next_reached;
    wire finish = start_data || dwell_end || ignore_home;

    // motion target
    wire [15:0] target = (state == st_press || state == st_jog) ? home_speed : 16'h0000;
    wire next_dir = (state == st_jog) ? host_cmd.jog_rev
                  : (state == st_press) ? ctrl[ctrl_dir_bit] : dir_cmd;

    // events and read data
    wire [ev_w-1:0] events = {next_reached && !torque_limit_reached, contact, finish};
    wire [ev_w-1:0] clr_bits = rd_status ? prdata[ev_w-1:0] : '0;
    wire [ev_w-1:0] next_status = (status & ~clr_bits) | events;
    logic [31:0] rdata;
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (paddr)
            reg_ctrl: rdata = ctrl;
            reg_speed: rdata = {16'h0000, home_speed};
            reg_home_pos: rdata = 32'(home_pos);
            reg_dwell: rdata = {16'h0000, dwell_ms};
            reg_stop_tlim: rdata = {16'h0000, stop_tlim};
            reg_int_tlim: rdata = {16'h0000, int_tlim};
            reg_fwd_tlim: rdata = {16'h0000, fwd_tlim};
            reg_rev_tlim: rdata = {16'h0000, rev_tlim};
            reg_accel: rdata = {16'h0000, accel};
            reg_status: rdata = {22'h000000, (state != st_idle), home_return_done,
                                 5'h00, status};
            reg_mask: rdata = {29'h00000000, mask};
            reg_position: rdata = 32'(position);
            default: rdata = 32'h0000_0000;
        endcase
    end

    // apb answer: zero wait states, data caught in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            prdata <= setup ? rdata : prdata;
            pslverr <= setup && !mapped;
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= ctrl_rst;
            home_speed <= 16'h0000;
            home_pos <= '0;
            dwell_ms <= 16'h0000;
            stop_tlim <= tlim_rst;
            int_tlim <= tlim_rst;
            fwd_tlim <= tlim_rst;
            rev_tlim <= tlim_rst;
            accel <= accel_rst;
            mask <= '0;
        end
        else if (wr_done)
        begin
            case (paddr)
                reg_ctrl: ctrl <= pwdata;
                reg_speed: home_speed <= pwdata[15:0];
                reg_home_pos: home_pos <= home_pos_w;
                reg_dwell: dwell_ms <= pwdata[15:0];
                reg_stop_tlim: stop_tlim <= pwdata[15:0];
                reg_int_tlim: int_tlim <= pwdata[15:0];
                reg_fwd_tlim: fwd_tlim <= pwdata[15:0];
                reg_rev_tlim: rev_tlim <= pwdata[15:0];
                reg_accel: accel <= pwdata[15:0];
                reg_mask: mask <= pwdata[ev_w-1:0];
                default: ;
            endcase
        end
    end

    // sequencer: a new stopper start drops done, only success raises it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= st_idle;
            home_return_done <= 1'b0;
            servo_on_q <= 1'b0;
        end
        else
        begin
            servo_on_q <= host_cmd.servo_on;
            case (state)
                st_idle, st_jog:
                    if (start_stop)
                        state <= st_press;
                    else
                        state <= jog_req ? st_jog : st_idle;
                st_press:
                    if (contact)
                        state <= st_dwell;
                st_dwell:
                    if (dwell_end)
                        state <= st_idle;
                default:
                    state <= st_idle;
            endcase
            if (finish)
                home_return_done <= 1'b1;
            else if (start_stop)
                home_return_done <= 1'b0;
        end
    end

    // dwell counters, cleared outside the dwell state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt <= 32'h0000_0000;
            dwell_cnt <= 16'h0000;
        end
        else if (state != st_dwell)
        begin
            ms_cnt <= 32'h0000_0000;
            dwell_cnt <= 16'h0000;
        end
        else
        begin
            ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            dwell_cnt <= ms_tick ? dwell_cnt + 16'h0001 : dwell_cnt;
        end
    end

    // position tracking; any completion loads the home value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            position <= '0;
        else if (finish)
            position <= home_pos;
        else if (dir_cmd)
            position <= position - POS_W'(speed_cmd);
        else
            position <= position + POS_W'(speed_cmd);
    end

    // drive outputs, status and interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_cmd <= 1'b0;
            torque_limit_cmd <= tlim_rst;
            torque_limit_reached <= 1'b0;
            status <= '0;
            irq <= 1'b0;
        end
        else
        begin
            dir_cmd <= next_dir;
            torque_limit_cmd <= next_tlim;
            torque_limit_reached <= next_reached;
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end

    speed_ramp #(.W(16)) ramp
    (
        .pclk(pclk),
        .presetn(presetn),
        .target(target),
        .step(accel),
        .speed(speed_cmd)
    );

    a_stop_tlim: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state == st_press) |-> torque_limit_cmd <= stop_tlim)
        else $error("stopper torque limit not applied");
    a_tlim_select: assert property (@(posedge pclk) disable iff (!presetn)
        (pressing && !host_cmd.internal_torque_limit_select) |=> torque_limit_cmd == $past(stop_tlim))
        else $error("wrong limit with internal select off");
    a_dwell_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_dwell && dwell_cnt < dwell_ms) |=> !home_return_done)
        else $error("done raised before dwell ended");
    a_done_drop: assert property (@(posedge pclk) disable iff (!presetn)
        start_stop |=> !home_return_done ##1 (!home_return_done throughout (state != st_idle)[*2]))
        else $error("done not dropped on new start");
    a_home_load: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> position == $past(home_pos) && home_return_done)
        else $error("home value not loaded");
    a_ignore_home: assert property (@(posedge pclk) disable iff (!presetn)
        (method == method_ignore && host_cmd.servo_on && !servo_on_q) |=> home_return_done)
        else $error("servo-on home not set");
    a_press_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_press) [*2] |-> dir_cmd == ctrl[ctrl_dir_bit])
        else $error("press direction wrong");
    a_tlim_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (!motor_torque[15] && torque_abs >= fwd_tlim) |=> torque_limit_reached)
        else $error("torque flag missed");
    a_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_idle && !no_point) |=> state != st_press)
        else $error("home start with point table selected");
    // bus answer, interrupt level and the smaller internal limit; a status read may clear, so it is excluded
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ((status & mask) != '0 && !rd_status) |=> irq)
        else $error("irq low with masked status set");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("apb answer not a single access cycle");
    a_stop_smaller: assert property (@(posedge pclk) disable iff (!presetn)
        (pressing && host_cmd.internal_torque_limit_select && int_tlim < stop_tlim)
        |=> torque_limit_cmd == $past(int_tlim))
        else $error("smaller internal limit not applied");
endmodule : home_return

// ---- bench/host_model.sv ----
// host controller on the cyclic link: turns bench requests into link bits
// assumes the bench drives its requests on pclk rising edges
module host_model
    import home_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic home_req,
    input wire logic start_req,
    input wire logic jog_req,
    input wire logic itl_req,
    input wire logic servo_req,
    output host_cmd_s host_cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    // one register stage stands for the link delay, so bench sets bits early
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_cmd <= '0;
        end
        else
        begin
            host_cmd.auto_manual_select <= home_req;
            host_cmd.point_table_select_low <= home_req ? 5'h00 : 5'h01;
            host_cmd.point_table_select_high <= home_req ? 3'h0 : 3'h4;
            host_cmd.pos_speed_spec_select <= home_req;
            host_cmd.internal_torque_limit_select <= itl_req;
            host_cmd.start <= start_req;
            host_cmd.jog_fwd <= jog_req; // never both jog bits at once
            host_cmd.jog_rev <= 1'b0;
            host_cmd.servo_on <= servo_req;
        end
    end
endmodule : host_model

// ---- bench/tb.sv ----
// self-checking bench for the home-return sequencer over APB and the host link
// assumes one pclk domain; dwell shortened to 4 cycles per ms
module tb
    import home_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int cpm = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic err, done, tflag, dir, irq, pready, pslverr;
    logic [31:0] prdata, position;
    logic [15:0] speed, tlim, sp0;
    logic signed [15:0] motor_torque = 16'sh0000;
    logic home_req = 1'b0, start_req = 1'b0, jog_req = 1'b0, itl_req = 1'b0, servo_req = 1'b0;
    host_cmd_s host_cmd;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;

    host_model host (.pclk(pclk), .presetn(presetn), .home_req(home_req),
        .start_req(start_req), .jog_req(jog_req), .itl_req(itl_req),
        .servo_req(servo_req), .host_cmd(host_cmd));
    home_return #(.POS_W(32), .CYC_PER_MS(cpm)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_cmd(host_cmd),
        .motor_torque(motor_torque), .home_return_done(done),
        .torque_limit_reached(tflag), .speed_cmd(speed), .dir_cmd(dir),
        .torque_limit_cmd(tlim), .position(position), .irq(irq));

    always #2.5 pclk = ~pclk;

    // hang guard: the tests need well under a thousand cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one APB transfer; request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cycles(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : cycles

    task wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 200)
        begin
            @(negedge pclk);
            k = k + 1;
        end
        // a wait that runs out counts against the run
        if (k == 200)
            n_mismatch = n_mismatch + 1;
    endtask : wait_done

    task test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and a refused address
        @(negedge pclk);
        check(tlim, 32'h0000_7fff);
        check(done, 1'b0);
        apb(1'b0, reg_ctrl, 32'h0);
        check(rd, ctrl_rst);
        apb(1'b0, reg_accel, 32'h0);
        check(rd, accel_rst);
        apb(1'b1, 8'h30, 32'h0000_00ff);
        check(err, 1'b1);
        apb(1'b0, 8'h30, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        $display("test reset done");

        // servo-on home outside home mode, then the done event and irq
        apb(1'b1, reg_home_pos, 32'h0000_0055);
        apb(1'b1, reg_ctrl, {28'h0, method_ignore});
        servo_req <= 1'b1;
        cycles(3);
        check(done, 1'b1);
        check(position, 32'h0000_0055);
        apb(1'b1, reg_mask, 32'h0000_0001);
        cycles(1);
        check(irq, 1'b1);
        apb(1'b0, reg_status, 32'h0);
        check({rd[live_done_bit], rd[ev_done]}, 2'b11);
        cycles(1);
        check(irq, 1'b0);
        $display("test ignore done");

        // jog to a spot, then data setting home there
        apb(1'b1, reg_ctrl, {28'h0, method_data_set});
        apb(1'b1, reg_speed, 32'h0000_0010);
        apb(1'b1, reg_accel, 32'h0000_0010);
        apb(1'b1, reg_home_pos, 32'h0000_1234);
        home_req <= 1'b1;
        jog_req <= 1'b1;
        cycles(6);
        check(position > 32'h0000_0055, 1'b1);
        jog_req <= 1'b0;
        cycles(4);
        start_req <= 1'b1;
        cycles(2);
        start_req <= 1'b0;
        wait_done();
        cycles(1);
        check(done, 1'b1);
        check(position, 32'h0000_1234);
        apb(1'b0, reg_status, 32'h0);
        check(rd[ev_w-1:0], 3'b001);
        $display("test data set done");

        // stopper limits with internal limit select on: the smaller of the two applies
        apb(1'b1, reg_ctrl, 32'h0000_0010 | method_stopper);
        apb(1'b1, reg_speed, 32'h0000_0040);
        apb(1'b1, reg_accel, 32'h0000_0003);
        apb(1'b1, reg_dwell, 32'h0000_0001);
        apb(1'b1, reg_stop_tlim, 32'h0000_0100);
        apb(1'b1, reg_int_tlim, 32'h0000_0080);
        apb(1'b1, reg_home_pos, 32'h0000_0777);
        apb(1'b1, reg_mask, 32'h0000_0004);
        itl_req <= 1'b1;
        start_req <= 1'b1;
        cycles(3);
        start_req <= 1'b0;
        check(done, 1'b0);
        check(tlim, 32'h0000_0080);
        check(dir, 1'b1);
        sp0 = speed;
        cycles(1);
        check(speed - sp0, 32'h0000_0003);
        cycles(30);
        check(speed, 32'h0000_0040);
        @(posedge pclk);
        motor_torque <= 16'sh0080;
        cycles(2);
        check(tflag, 1'b1);
        check(irq, 1'b1);
        check(done, 1'b0);
        wait_done();
        check(done, 1'b1);
        check(position, 32'h0000_0777);
        apb(1'b0, reg_status, 32'h0);
        check(rd[ev_w-1:0], 3'b111);
        @(posedge pclk);
        motor_torque <= 16'sh0000;
        itl_req <= 1'b0;
        apb(1'b1, reg_int_tlim, 32'h0000_0200);
        itl_req <= 1'b1;
        start_req <= 1'b1;
        cycles(3);
        start_req <= 1'b0;
        check(tlim, 32'h0000_0100);
        @(posedge pclk);
        motor_torque <= -16'sh0100;
        wait_done();
        check(position, 32'h0000_0777);
        check(done, 1'b1);
        $display("test stopper done");

        // start outside home mode must be refused
        home_req <= 1'b0;
        start_req <= 1'b1;
        cycles(4);
        start_req <= 1'b0;
        check(done, 1'b1);
        apb(1'b0, reg_status, 32'h0);
        check(rd[live_busy_bit], 1'b0);
        $display("test mode gate done");
        test_done();
    end
endmodule : tb
